// ==== design/ecc_clock_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
module ecc_clock_gen (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic run,
   input wire logic invert,
   input wire logic [ecc_pkg::DIV_W-1:0] ratio,
   output logic clk_out_q,
   output logic busy_q
);
   import ecc_pkg::*;

   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] ratio_q;
   logic inv_q;
   wire logic last_tick = (cnt_q == ratio_q);
   wire logic at_idle = (clk_out_q == inv_q);

   // Ratio and idle level are only taken while stopped, so a running
   // clock never sees a half period cut short.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_out_q <= 1'b0;
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
         ratio_q <= 8'h00;
         inv_q <= 1'b0;
      end else if (!busy_q) begin
         clk_out_q <= invert;
         inv_q <= invert;
         cnt_q <= 8'h00;
         ratio_q <= ratio;
         busy_q <= run;
      end else if (!run && at_idle) begin
         busy_q <= 1'b0;
      end else if (tick) begin
         if (last_tick) begin
            clk_out_q <= ~clk_out_q;
            cnt_q <= 8'h00;
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ==== design/ecc_pkg.sv ====
package ecc_pkg;
   // Register byte offsets on the AXI4-Lite port.
   localparam logic [7:0] OFF_SEC = 8'h00;
   localparam logic [7:0] OFF_MAIN = 8'h04;
   localparam logic [7:0] OFF_CAM = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0c;
   localparam int ADDR_W = 8;
   // Secondary clock control fields.
   localparam int SEC_SRC_BIT = 0;
   localparam int SEC_DIS_BIT = 1;
   localparam int SEC_SW_BIT = 2;
   localparam int SEC_INV_BIT = 3;
   localparam int SEC_PLL_BIT = 4;
   localparam int SEC_RATIO_LSB = 8;
   localparam int SEC_RATIO_W = 6;
   localparam logic [31:0] SEC_MASK = 32'h0000_3f1f;
   localparam logic [31:0] SEC_RST = 32'h0000_0000;
   // Main request and system clock output fields.
   localparam int MAIN_EN_BIT = 0;
   localparam int MAIN_DIS_BIT = 1;
   localparam int MAIN_SW_BIT = 2;
   localparam logic [31:0] MAIN_MASK = 32'h0000_0007;
   localparam logic [31:0] MAIN_RST = 32'h0000_0000;
   // Camera sensor clock fields.
   localparam int CAM_EN_BIT = 0;
   localparam int CAM_RATIO_LSB = 8;
   localparam int DIV_W = 8;
   localparam logic [31:0] CAM_MASK = 32'h0000_ff01;
   localparam logic [31:0] CAM_RST = 32'h0000_0000;
   // Status bits.
   localparam int ST_SEC_BIT = 0;
   localparam int ST_SYS_BIT = 1;
   localparam int ST_CAM_BIT = 2;
   localparam int ST_PLL_BIT = 3;
   localparam int ST_SEC_HW_BIT = 4;
   localparam int ST_MAIN_HW_BIT = 5;
   // Divider ratio used for a clock that follows the system clock.
   localparam logic [DIV_W-1:0] DIV_NONE = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== design/ecc_top.sv ====
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ecc_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ecc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ecc_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic secondary_clock_hw_request,
   input wire logic main_clock_hw_request,
   input wire logic pll_edge_tick,
   output logic secondary_clock_out,
   output logic camera_sensor_clock_out,
   output logic system_clock_pin_out,
   output logic fixed_48m_pll_enable
);
   import ecc_pkg::*;

   function automatic logic req_wanted(logic dis, logic sw, logic hw);
      // With the disable bit set the pin is ignored entirely.
      req_wanted = sw | (~dis & hw);
   endfunction

   function automatic logic [31:0] merge(logic [31:0] old,
                                         logic [31:0] data,
                                         logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge[8*i +: 8] = data[8*i +: 8];
         end
      end
   endfunction

   // Pin synchronisers: three flops, a change counts once two agree.
   logic [1:0] pin_raw;
   logic [1:0] sy1_q;
   logic [1:0] sy2_q;
   logic [1:0] sy3_q;
   logic [1:0] pin_q;
   assign pin_raw = {main_clock_hw_request, secondary_clock_hw_request};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sy1_q[g] <= 1'b0;
               sy2_q[g] <= 1'b0;
               sy3_q[g] <= 1'b0;
               pin_q[g] <= 1'b0;
            end else begin
               sy1_q[g] <= pin_raw[g];
               sy2_q[g] <= sy1_q[g];
               sy3_q[g] <= sy2_q[g];
               if (sy2_q[g] == sy3_q[g]) begin
                  pin_q[g] <= sy3_q[g];
               end
            end
         end
      end
   endgenerate

   wire logic sec_hw = pin_q[0];
   wire logic main_hw = pin_q[1];

   // Register file.
   logic [31:0] sec_q;
   logic [31:0] main_q;
   logic [31:0] cam_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   wire logic aw_fire = s_axi_awvalid & s_axi_awready;
   wire logic w_fire = s_axi_wvalid & s_axi_wready;
   wire logic do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   wire logic wr_sec = do_write & (awaddr_q == OFF_SEC);
   wire logic wr_main = do_write & (awaddr_q == OFF_MAIN);
   wire logic wr_cam = do_write & (awaddr_q == OFF_CAM);
   wire logic wr_ok = wr_sec | wr_main | wr_cam | (awaddr_q == OFF_STAT);

   wire logic sec_sel = sec_q[SEC_SRC_BIT];
   wire logic sec_dis = sec_q[SEC_DIS_BIT];
   wire logic sec_sw = sec_q[SEC_SW_BIT];
   wire logic sec_pll = sec_q[SEC_PLL_BIT];
   wire logic main_en = main_q[MAIN_EN_BIT];
   wire logic main_dis = main_q[MAIN_DIS_BIT];
   wire logic main_sw = main_q[MAIN_SW_BIT];
   wire logic cam_en = cam_q[CAM_EN_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_q <= SEC_RST;
         main_q <= MAIN_RST;
         cam_q <= CAM_RST;
      end else begin
         if (wr_sec) begin
            sec_q <= merge(sec_q, wdata_q, wstrb_q) & SEC_MASK;
         end
         if (wr_main) begin
            main_q <= merge(main_q, wdata_q, wstrb_q) & MAIN_MASK;
         end
         if (wr_cam) begin
            cam_q <= merge(cam_q, wdata_q, wstrb_q) & CAM_MASK;
         end
      end
   end

   // Write channel: address and data are taken in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_fire) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read channel.
   logic sec_busy;
   logic sys_busy;
   logic cam_busy;
   logic [31:0] stat_word;
   logic [31:0] rd_word;
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[ST_SEC_BIT] = sec_busy;
      stat_word[ST_SYS_BIT] = sys_busy;
      stat_word[ST_CAM_BIT] = cam_busy;
      stat_word[ST_PLL_BIT] = fixed_48m_pll_enable;
      stat_word[ST_SEC_HW_BIT] = sec_hw;
      stat_word[ST_MAIN_HW_BIT] = main_hw;
   end
   assign rd_word = (s_axi_araddr == OFF_SEC) ? sec_q :
                    (s_axi_araddr == OFF_MAIN) ? main_q :
                    (s_axi_araddr == OFF_CAM) ? cam_q : stat_word;
   wire logic rd_ok = (s_axi_araddr == OFF_SEC) |
                      (s_axi_araddr == OFF_MAIN) |
                      (s_axi_araddr == OFF_CAM) |
                      (s_axi_araddr == OFF_STAT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_ok ? rd_word : 32'h0000_0000;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Secondary clock. The source in use only follows the select bit
   // while the output is stopped, so a source swap first parks the pin.
   logic sec_src_q;
   wire logic sec_req = sec_sel ? req_wanted(sec_dis, sec_sw, sec_hw)
                                : sec_pll;
   wire logic sec_run = sec_req & (sec_src_q == sec_sel);
   wire logic sec_tick = sec_src_q | (pll_edge_tick & fixed_48m_pll_enable);
   wire logic [DIV_W-1:0] sec_ratio = sec_src_q ? DIV_NONE :
      {2'h0, sec_q[SEC_RATIO_LSB +: SEC_RATIO_W]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_src_q <= 1'b0;
         fixed_48m_pll_enable <= 1'b0;
      end else begin
         if (!sec_busy) begin
            sec_src_q <= sec_sel;
         end
         // The PLL stays up until a PLL-fed output has parked.
         fixed_48m_pll_enable <= (sec_pll & ~sec_sel) |
                                 (sec_busy & ~sec_src_q);
      end
   end

   ecc_clock_gen u_sec (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(sec_tick),
      .run(sec_run),
      .invert(sec_q[SEC_INV_BIT]),
      .ratio(sec_ratio),
      .clk_out_q(secondary_clock_out),
      .busy_q(sec_busy)
   );

   // System clock pin shares the main request pin and software bit.
   wire logic sys_run = main_en & req_wanted(main_dis, main_sw, main_hw);

   ecc_clock_gen u_sys (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(1'b1),
      .run(sys_run),
      .invert(1'b0),
      .ratio(DIV_NONE),
      .clk_out_q(system_clock_pin_out),
      .busy_q(sys_busy)
   );

   // Camera clock has no pin request path at all.
   ecc_clock_gen u_cam (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(1'b1),
      .run(cam_en),
      .invert(1'b0),
      .ratio(cam_q[CAM_RATIO_LSB +: DIV_W]),
      .clk_out_q(camera_sensor_clock_out),
      .busy_q(cam_busy)
   );

   sequence s_sec_hw_cfg;
      sec_src_q && sec_sel && !sec_dis && !sec_sw && sec_hw;
   endsequence
   sequence s_sec_masked;
      (sec_src_q && sec_sel && sec_dis && !sec_sw) [*4];
   endsequence

   AST_PIN_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pin_q[0]) |-> $past(secondary_clock_hw_request, 3))
      else $error("secondary request rose without a held pin");
   AST_SEC_HW_START: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_sec_hw_cfg and !sec_busy) |=> sec_busy)
      else $error("pin request did not start secondary clock");
   AST_SEC_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
      s_sec_masked |-> !sec_busy)
      else $error("secondary clock kept running while masked");
   AST_SEC_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
      (!sec_busy) [*2] |-> secondary_clock_out == $past(sec_q[SEC_INV_BIT]))
      else $error("secondary idle level wrong");
   AST_SEC_SW: assert property (@(posedge aclk) disable iff (!aresetn)
      (sec_src_q && sec_sel && sec_dis && sec_sw && !sec_busy) |=> sec_busy)
      else $error("software request did not start secondary clock");
   AST_SEC_PLL: assert property (@(posedge aclk) disable iff (!aresetn)
      (!sec_src_q && !sec_sel && sec_pll && !sec_busy) |=> sec_busy)
      else $error("PLL request did not start secondary clock");
   AST_PLL_ON: assert property (@(posedge aclk) disable iff (!aresetn)
      (sec_pll && !sec_sel) [*2] |-> fixed_48m_pll_enable)
      else $error("PLL idle while requested");
   AST_SEC_GLITCH: assert property (@(posedge aclk) disable iff (!aresetn)
      ($changed(secondary_clock_out) && $past(sec_busy)) |->
      $past(sec_tick) && ($past(sec_run) || $past(secondary_clock_out ^
      u_sec.inv_q)))
      else $error("secondary clock toggled off a tick");
   AST_SYS_HW: assert property (@(posedge aclk) disable iff (!aresetn)
      (main_en && !main_dis && main_hw && !sys_busy) |=> sys_busy)
      else $error("main pin did not start system clock output");
   AST_SYS_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
      (main_dis && !main_sw) [*4] |-> !sys_busy)
      else $error("system clock output not masked");
   AST_SYS_SW: assert property (@(posedge aclk) disable iff (!aresetn)
      (main_en && main_dis && main_sw && !sys_busy) |=> sys_busy)
      else $error("software did not start system clock output");
   AST_SYS_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      (!main_en) [*4] |-> !sys_busy && !system_clock_pin_out)
      else $error("system clock output not stopped");
   AST_CAM_START: assert property (@(posedge aclk) disable iff (!aresetn)
      (cam_en && !cam_busy) |=> cam_busy ##1 (cam_busy || !cam_en))
      else $error("camera clock did not start");
endmodule
`default_nettype wire

// ==== tb/ecc_ext_ic.sv ====
`timescale 1ns/1ns
`default_nettype none
module ecc_ext_ic (
   input wire logic aclk,
   input wire logic sec_want,
   input wire logic main_want,
   input wire logic pll_enable,
   output logic secondary_clock_hw_request,
   output logic main_clock_hw_request,
   output logic pll_edge_tick
);
   logic junk_q;
   initial begin
      secondary_clock_hw_request = 1'b0;
      main_clock_hw_request = 1'b0;
      junk_q = 1'b0;
   end
   // The pins come from another chip; here they follow sec_want and main_want
   // one rising aclk edge later, and are still synchronised on the inside.
   always @(posedge aclk) begin
      secondary_clock_hw_request <= sec_want;
      main_clock_hw_request <= main_want;
      junk_q <= ~junk_q;
   end
   // A stopped PLL gives no clean ticks, so garbage is shown instead.
   assign pll_edge_tick = pll_enable ? 1'b1 : junk_q;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
   import ecc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic sec_req, main_req, tick, sec_out, cam_out, sys_out, pll_en;
   logic sec_want = 1'b0, main_want = 1'b0;
   int bad_count = 0, n_checks = 0, cyc = 0, r;

   always #25 aclk = ~aclk;

   ecc_top ecc_top_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .secondary_clock_hw_request(sec_req),
      .main_clock_hw_request(main_req), .pll_edge_tick(tick),
      .secondary_clock_out(sec_out), .camera_sensor_clock_out(cam_out),
      .system_clock_pin_out(sys_out), .fixed_48m_pll_enable(pll_en));

   ecc_ext_ic ecc_ext_ic_inst (.aclk(aclk), .sec_want(sec_want),
      .main_want(main_want), .pll_enable(pll_en),
      .secondary_clock_hw_request(sec_req),
      .main_clock_hw_request(main_req), .pll_edge_tick(tick));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Handshake readies are read right after the edge, before the design's
   // registers update, so they show the value that the edge sampled.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      chk("bresp", 32'(er), 32'(s_axi_bresp));
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      s_axi_rready <= 1'b0;
   endtask

   function automatic logic pick(input int sel);
      return (sel == 0) ? sec_out : (sel == 1) ? cam_out : sys_out;
   endfunction

   // Lets the output settle, then counts edges over four half periods.
   task automatic clk_chk(input int sel, input int per, input logic run,
                          input logic lvl);
      int n;
      logic p, v;
      n = 0;
      repeat (16) @(posedge aclk);
      @(negedge aclk);
      p = pick(sel);
      repeat (4 * per) begin
         @(negedge aclk);
         v = pick(sel);
         if (v !== p) n++;
         p = v;
      end
      chk("toggles", run ? 32'd4 : 32'd0, 32'(n));
      if (!run) chk("idle level", {31'h0, lvl}, {31'h0, p});
      @(posedge aclk);
   endtask

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 4; i++) axi_rd(8'(4 * i), 32'h0, RESP_OKAY);
      axi_rd(8'h10, 32'h0, RESP_SLVERR);
      axi_wr(8'h10, 32'h1, RESP_SLVERR);
      axi_wr(OFF_STAT, 32'h1, RESP_OKAY);
      axi_rd(OFF_STAT, 32'h0, RESP_OKAY);
      axi_wr(OFF_SEC, ~SEC_MASK, RESP_OKAY);
      axi_rd(OFF_SEC, 32'h0, RESP_OKAY);
      axi_wr(OFF_SEC, 32'h1, RESP_OKAY);
      clk_chk(0, 1, 1'b0, 1'b0);
      sec_want <= 1'b1;
      clk_chk(0, 1, 1'b1, 1'b0);
      axi_rd(OFF_STAT, 32'h11, RESP_OKAY);
      axi_wr(OFF_SEC, 32'h3, RESP_OKAY);
      clk_chk(0, 1, 1'b0, 1'b0);
      sec_want <= 1'b0;
      repeat (8) @(posedge aclk);
      axi_wr(OFF_SEC, 32'h9, RESP_OKAY);
      clk_chk(0, 1, 1'b0, 1'b1);
      axi_wr(OFF_SEC, 32'h7, RESP_OKAY);
      clk_chk(0, 1, 1'b1, 1'b0);
      sec_want <= 1'b1;
      axi_wr(OFF_SEC, 32'h3, RESP_OKAY);
      clk_chk(0, 1, 1'b0, 1'b0);
      sec_want <= 1'b0;
      for (r = 0; r < 3; r++) begin
         axi_wr(OFF_SEC, 32'h10 | 32'(r << 8), RESP_OKAY);
         clk_chk(0, r + 1, 1'b1, 1'b0);
         axi_rd(OFF_STAT, 32'h9, RESP_OKAY);
         axi_wr(OFF_SEC, 32'(r << 8), RESP_OKAY);
         clk_chk(0, r + 1, 1'b0, 1'b0);
         axi_rd(OFF_STAT, 32'h0, RESP_OKAY);
      end
      for (r = 0; r < 4; r += 3) begin
         axi_wr(OFF_CAM, 32'(r << 8), RESP_OKAY);
         clk_chk(1, r + 1, 1'b0, 1'b0);
         axi_wr(OFF_CAM, 32'(r << 8) | 32'h1, RESP_OKAY);
         clk_chk(1, r + 1, 1'b1, 1'b0);
      end
      main_want <= 1'b1;
      axi_wr(OFF_CAM, 32'h0300, RESP_OKAY);
      clk_chk(1, 4, 1'b0, 1'b0);
      axi_wr(OFF_MAIN, 32'h1, RESP_OKAY);
      clk_chk(2, 1, 1'b1, 1'b0);
      axi_wr(OFF_MAIN, 32'h3, RESP_OKAY);
      clk_chk(2, 1, 1'b0, 1'b0);
      axi_wr(OFF_MAIN, 32'h1, RESP_OKAY);
      clk_chk(2, 1, 1'b1, 1'b0);
      axi_wr(OFF_MAIN, 32'h0, RESP_OKAY);
      clk_chk(2, 1, 1'b0, 1'b0);
      main_want <= 1'b0;
      repeat (8) @(posedge aclk);
      axi_wr(OFF_MAIN, 32'h7, RESP_OKAY);
      clk_chk(2, 1, 1'b1, 1'b0);
      axi_rd(OFF_MAIN, 32'h7, RESP_OKAY);
      axi_wr(OFF_MAIN, 32'h3, RESP_OKAY);
      clk_chk(2, 1, 1'b0, 1'b0);
      axi_wr(OFF_MAIN, 32'h7, RESP_OKAY);
      clk_chk(2, 1, 1'b1, 1'b0);
      axi_wr(OFF_MAIN, 32'h6, RESP_OKAY);
      clk_chk(2, 1, 1'b0, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
